// ===== hdl/tsic_timer.sv
// Function
// - Capture-2 edge sets flag, optional interrupt
// - Status then capture-2 low read clears flag
// - Compare-1 match sets flag, optional interrupt
// - Status then compare-1 low access clears
// - Counter wrap sets overflow flag, optional interrupt
// - Status then counter low read clears overflow
// - Status read or write arms overflow clear
// - Status shows both capture input levels
// - Compare-2 flag set, interrupt, cleared via 27
// - Capture 1 latches counter, bytes 20/21
// - Capture 2 latches counter, bytes 24/25
// - Captured value is counter plus one
// - Resolution one count, four bus cycles
// - Every unblocked valid edge overwrites capture register
// - High byte read blocks capture until low
// - Low byte read alone never blocks capture
// - Reset leaves capture contents unchanged
// - Capture interrupt enables gate capture interrupt requests
// - Compare registers read/write, never hardware-altered
// - Any status access is first clear step
// - Status then capture-1 low read clears flag
// - Edge-select one means rising, zero falling
// - Counter advances through divide-by-four prescaler
`timescale 1ns/100ps
`include "tsic_map.svh"

module tsic_timer
    import tsic_pkg::*;
(
    input wire logic core_clk, // 200 MHz bus clock
    input wire logic srst, // Synchronous reset, active high
    input wire logic clk_en, // Freezes all state when low
    input wire tsic_bus_t bus_req, // CPU register access
    input wire tsic_ctl_t ctl, // Edge selects and interrupt enables
    input wire logic capture_input_one, // Capture pin 1, asynchronous
    input wire logic capture_input_two, // Capture pin 2, asynchronous
    output logic [7:0] rd_data, // Read data, valid cycle after rd
    output logic irq_req // Combined timer interrupt request
);

    logic [1:0] pre_q;
    logic [15:0] cnt_q;
    logic [1:0] sync1_q;
    logic [1:0] sync2_q;
    logic [1:0] sync3_q;
    logic [15:0] cap_q [2];
    logic [1:0] cap_inh_q;
    logic [15:0] cmp_q [2];
    logic [1:0] cmp_inh_q;
    logic [4:0] flag_q;
    logic [4:0] arm_q;
    logic [7:0] lo_buf_q;
    logic lo_buf_v_q;
    logic [7:0] rd_data_q;
    logic irq_q;

    logic tick;
    logic acc;
    logic rd_en;
    logic wr_en;
    logic flags_acc;
    logic [1:0] edge_sel;
    logic [1:0] cap_ev;
    logic [1:0] cap_hi_rd;
    logic [1:0] cap_lo_rd;
    logic [1:0] cmp_hi_wr;
    logic [1:0] cmp_lo_wr;
    logic [1:0] cmp_match;
    logic [4:0] set_ev;
    logic [4:0] clr_acc;
    logic [4:0] irq_en;
    logic [7:0] flags_byte;
    logic [7:0] rd_mux;

    assign tick = clk_en && (pre_q == `TSIC_PRESCALE_LAST);
    assign rd_en = clk_en && bus_req.rd;
    assign wr_en = clk_en && bus_req.wr;
    assign acc = rd_en || wr_en;
    assign flags_acc = acc && (bus_req.addr == `TSIC_ADDR_FLAGS);
    assign edge_sel = {ctl.edge_select_two, ctl.edge_select_one};

    assign cap_hi_rd[0] = rd_en && (bus_req.addr == `TSIC_ADDR_CAP1_HI);
    assign cap_hi_rd[1] = rd_en && (bus_req.addr == `TSIC_ADDR_CAP2_HI);
    assign cap_lo_rd[0] = rd_en && (bus_req.addr == `TSIC_ADDR_CAP1_LO);
    assign cap_lo_rd[1] = rd_en && (bus_req.addr == `TSIC_ADDR_CAP2_LO);
    assign cmp_hi_wr[0] = wr_en && (bus_req.addr == `TSIC_ADDR_CMP1_HI);
    assign cmp_hi_wr[1] = wr_en && (bus_req.addr == `TSIC_ADDR_CMP2_HI);
    assign cmp_lo_wr[0] = wr_en && (bus_req.addr == `TSIC_ADDR_CMP1_LO);
    assign cmp_lo_wr[1] = wr_en && (bus_req.addr == `TSIC_ADDR_CMP2_LO);

    // Prescaler and free-running counter
    always_ff @(posedge core_clk) begin
        if (srst) begin
            pre_q <= 2'h0;
            cnt_q <= `TSIC_CNT_RESET;
        end else if (clk_en) begin
            pre_q <= pre_q + 2'h1;
            if (tick) begin
                cnt_q <= cnt_q + 16'h0001;
            end
        end
    end

    // Pin synchronisers; edge logic reads stages two and three only
    always_ff @(posedge core_clk) begin
        if (srst) begin
            sync1_q <= 2'h3;
            sync2_q <= 2'h3;
            sync3_q <= 2'h3;
        end else if (clk_en) begin
            sync1_q <= {capture_input_two, capture_input_one};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    generate
        for (genvar i = 0; i < 2; i++) begin : g_edge
            assign cap_ev[i] = clk_en && (edge_sel[i] ? (sync2_q[i] && !sync3_q[i])
                                                      : (!sync2_q[i] && sync3_q[i]));
        end
    endgenerate

    // Capture registers carry no reset so a reset leaves them intact
    always_ff @(posedge core_clk) begin
        for (int i = 0; i < 2; i++) begin
            if (cap_ev[i] && !cap_inh_q[i]) begin
                cap_q[i] <= cnt_q + 16'h0001;
            end
        end
    end

    // A high read in the same cycle as an edge still lets the edge through
    always_ff @(posedge core_clk) begin
        if (srst) begin
            cap_inh_q <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (cap_hi_rd[i]) begin
                    cap_inh_q[i] <= 1'b1;
                end else if (cap_lo_rd[i]) begin
                    cap_inh_q[i] <= 1'b0;
                end
            end
        end
    end

    // Compare storage, no reset and never written by hardware
    always_ff @(posedge core_clk) begin
        for (int i = 0; i < 2; i++) begin
            if (cmp_hi_wr[i]) begin
                cmp_q[i][15:8] <= bus_req.wdata;
            end
            if (cmp_lo_wr[i]) begin
                cmp_q[i][7:0] <= bus_req.wdata;
            end
        end
    end

    // High write holds off compares until the low byte lands
    always_ff @(posedge core_clk) begin
        if (srst) begin
            cmp_inh_q <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (cmp_hi_wr[i]) begin
                    cmp_inh_q[i] <= 1'b1;
                end else if (cmp_lo_wr[i]) begin
                    cmp_inh_q[i] <= 1'b0;
                end
            end
        end
    end

    generate
        for (genvar i = 0; i < 2; i++) begin : g_cmp
            assign cmp_match[i] = tick && !cmp_inh_q[i] && (cnt_q == cmp_q[i]);
        end
    endgenerate

    assign set_ev[`TSIC_F_CAP1] = cap_ev[0];
    assign set_ev[`TSIC_F_CAP2] = cap_ev[1];
    assign set_ev[`TSIC_F_CMP1] = cmp_match[0];
    assign set_ev[`TSIC_F_CMP2] = cmp_match[1];
    assign set_ev[`TSIC_F_OVF] = tick && (cnt_q == `TSIC_CNT_MAX);

    assign clr_acc[`TSIC_F_CAP1] = cap_lo_rd[0];
    assign clr_acc[`TSIC_F_CAP2] = cap_lo_rd[1];
    assign clr_acc[`TSIC_F_CMP1] = acc && (bus_req.addr == `TSIC_ADDR_CMP1_LO);
    assign clr_acc[`TSIC_F_CMP2] = acc && (bus_req.addr == `TSIC_ADDR_CMP2_LO);
    assign clr_acc[`TSIC_F_OVF] = rd_en && (bus_req.addr == `TSIC_ADDR_CNT_LO);

    // Arm on any flag access; the alternate counter never disarms or clears
    always_ff @(posedge core_clk) begin
        if (srst) begin
            arm_q <= 5'h00;
        end else if (flags_acc) begin
            arm_q <= flag_q;
        end else begin
            arm_q <= arm_q & ~clr_acc & flag_q;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            flag_q <= 5'h00;
        end else begin
            flag_q <= set_ev | (flag_q & ~(arm_q & clr_acc));
        end
    end

    // Counter low-byte buffer frozen by the first high read
    always_ff @(posedge core_clk) begin
        if (srst) begin
            lo_buf_q <= 8'h00;
            lo_buf_v_q <= 1'b0;
        end else if (rd_en) begin
            if ((bus_req.addr == `TSIC_ADDR_CNT_HI) || (bus_req.addr == `TSIC_ADDR_ALT_HI)) begin
                if (!lo_buf_v_q) begin
                    lo_buf_q <= cnt_q[7:0];
                    lo_buf_v_q <= 1'b1;
                end
            end else if ((bus_req.addr == `TSIC_ADDR_CNT_LO) ||
                         (bus_req.addr == `TSIC_ADDR_ALT_LO)) begin
                lo_buf_v_q <= 1'b0;
            end
        end
    end

    always_comb begin
        flags_byte = 8'h00;
        flags_byte[`TSIC_BIT_CAP1_FLAG] = flag_q[`TSIC_F_CAP1];
        flags_byte[`TSIC_BIT_CAP2_FLAG] = flag_q[`TSIC_F_CAP2];
        flags_byte[`TSIC_BIT_CMP1_FLAG] = flag_q[`TSIC_F_CMP1];
        flags_byte[`TSIC_BIT_CMP2_FLAG] = flag_q[`TSIC_F_CMP2];
        flags_byte[`TSIC_BIT_OVF_FLAG] = flag_q[`TSIC_F_OVF];
        flags_byte[`TSIC_BIT_CAP1_PIN] = sync2_q[0];
        flags_byte[`TSIC_BIT_CAP2_PIN] = sync2_q[1];
    end

    always_comb begin
        unique case (bus_req.addr)
            `TSIC_ADDR_CAP1_HI: rd_mux = cap_q[0][15:8];
            `TSIC_ADDR_CAP1_LO: rd_mux = cap_q[0][7:0];
            `TSIC_ADDR_CMP1_HI: rd_mux = cmp_q[0][15:8];
            `TSIC_ADDR_CMP1_LO: rd_mux = cmp_q[0][7:0];
            `TSIC_ADDR_CAP2_HI: rd_mux = cap_q[1][15:8];
            `TSIC_ADDR_CAP2_LO: rd_mux = cap_q[1][7:0];
            `TSIC_ADDR_CMP2_HI: rd_mux = cmp_q[1][15:8];
            `TSIC_ADDR_CMP2_LO: rd_mux = cmp_q[1][7:0];
            `TSIC_ADDR_CNT_HI, `TSIC_ADDR_ALT_HI: rd_mux = cnt_q[15:8];
            `TSIC_ADDR_CNT_LO, `TSIC_ADDR_ALT_LO: rd_mux = lo_buf_v_q ? lo_buf_q : cnt_q[7:0];
            `TSIC_ADDR_FLAGS: rd_mux = flags_byte;
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            rd_data_q <= 8'h00;
        end else if (rd_en) begin
            rd_data_q <= rd_mux;
        end
    end

    assign irq_en[`TSIC_F_CAP1] = ctl.capture_one_irq_en;
    assign irq_en[`TSIC_F_CAP2] = ctl.capture_two_irq_en;
    assign irq_en[`TSIC_F_CMP1] = ctl.compare_one_irq_en;
    assign irq_en[`TSIC_F_CMP2] = ctl.compare_two_irq_en;
    assign irq_en[`TSIC_F_OVF] = ctl.overflow_irq_en;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            irq_q <= 1'b0;
        end else if (clk_en) begin
            irq_q <= |(flag_q & irq_en);
        end
    end

    assign rd_data = rd_data_q;
    assign irq_req = irq_q;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    cap_two_set_a: assert property (cap_ev[1] |=> flag_q[`TSIC_F_CAP2])
        else $error("capture two flag not set by edge");
    cap_two_clr_a: assert property (arm_q[`TSIC_F_CAP2] && cap_lo_rd[1] && !cap_ev[1]
        |=> !flag_q[`TSIC_F_CAP2])
        else $error("capture two flag not cleared");
    set_wins_a: assert property (set_ev != 5'h00
        |=> (flag_q & $past(set_ev)) == $past(set_ev))
        else $error("flag event lost to a clear");
    cap_value_a: assert property (cap_ev[0] && !cap_inh_q[0]
        |=> cap_q[0] == $past(cnt_q) + 16'h0001)
        else $error("capture one value wrong");
    cap_block_a: assert property (cap_inh_q[0] && cap_ev[0] |=> $stable(cap_q[0]))
        else $error("capture one not blocked after high read");
    cap_inh_set_a: assert property (cap_hi_rd[0] |=> cap_inh_q[0])
        else $error("capture one high read did not block");
    ovf_wrap_a: assert property (tick && cnt_q == `TSIC_CNT_MAX
        |=> cnt_q == 16'h0000 && flag_q[`TSIC_F_OVF])
        else $error("overflow not flagged on wrap");
    prescale_a: assert property (tick |=> !tick ##1 !tick ##1 !tick)
        else $error("counter advanced faster than one in four");
    ovf_clr_a: assert property (flags_acc && flag_q[`TSIC_F_OVF] ##[1:2]
        (clr_acc[`TSIC_F_OVF] && !set_ev[`TSIC_F_OVF]) |=> !flag_q[`TSIC_F_OVF])
        else $error("overflow clear sequence failed");
    cmp_keep_a: assert property (!cmp_hi_wr[0] && !cmp_lo_wr[0] |=> $stable(cmp_q[0]))
        else $error("compare one changed without a write");
    pin_level_a: assert property (rd_en && bus_req.addr == `TSIC_ADDR_FLAGS
        |=> rd_data[`TSIC_BIT_CAP1_PIN] == $past(sync2_q[0]))
        else $error("capture one pin level misreported");

endmodule : tsic_timer

// ===== hdl/tsic_map.svh
`ifndef TSIC_MAP_SVH
`define TSIC_MAP_SVH

// Register addresses on the internal bus
`define TSIC_ADDR_CAP1_HI 8'h20
`define TSIC_ADDR_CAP1_LO 8'h21
`define TSIC_ADDR_CMP1_HI 8'h22
`define TSIC_ADDR_CMP1_LO 8'h23
`define TSIC_ADDR_CAP2_HI 8'h24
`define TSIC_ADDR_CAP2_LO 8'h25
`define TSIC_ADDR_CMP2_HI 8'h26
`define TSIC_ADDR_CMP2_LO 8'h27
`define TSIC_ADDR_CNT_HI 8'h28
`define TSIC_ADDR_CNT_LO 8'h29
`define TSIC_ADDR_ALT_HI 8'h2A
`define TSIC_ADDR_ALT_LO 8'h2B
`define TSIC_ADDR_FLAGS 8'h2E

// Flag register bit positions
`define TSIC_BIT_CAP1_FLAG 7
`define TSIC_BIT_CMP1_FLAG 6
`define TSIC_BIT_OVF_FLAG 5
`define TSIC_BIT_CAP1_PIN 4
`define TSIC_BIT_CAP2_PIN 3
`define TSIC_BIT_CAP2_FLAG 2
`define TSIC_BIT_CMP2_FLAG 1

// Internal flag vector indices
`define TSIC_F_CAP1 0
`define TSIC_F_CAP2 1
`define TSIC_F_CMP1 2
`define TSIC_F_CMP2 3
`define TSIC_F_OVF 4

// Reset values and timing
`define TSIC_CNT_RESET 16'hFFFC
`define TSIC_CNT_MAX 16'hFFFF
`define TSIC_PRESCALE_DIV 4
`define TSIC_PRESCALE_LAST 2'h3

`endif

// ===== hdl/tsic_pkg.sv
package tsic_pkg;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tsic_bus_t;

    typedef struct packed {
        logic edge_select_one;
        logic edge_select_two;
        logic capture_one_irq_en;
        logic capture_two_irq_en;
        logic compare_one_irq_en;
        logic compare_two_irq_en;
        logic overflow_irq_en;
    } tsic_ctl_t;

endpackage : tsic_pkg

// ===== verification/tsic_cpu_model.sv
`timescale 1ns/100ps
`include "tsic_map.svh"

module tsic_cpu_model
    import tsic_pkg::*;
(
    input wire logic core_clk, // Bus clock
    input wire logic [7:0] rd_data, // Read data from the timer
    output tsic_bus_t bus_req // Register access strobes
);
    initial bus_req = '0;

    // Strobe stands for one taken edge; a released address is inverted, never left stale
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] wd,
        output logic [7:0] d);
        @(posedge core_clk);
        #1;
        bus_req = '{rd: !w, wr: w, addr: a, wdata: wd};
        @(posedge core_clk);
        #1;
        d = rd_data;
        bus_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~wd};
    endtask : access

    task automatic read(input logic [7:0] a, output logic [7:0] d);
        access(1'b0, a, 8'h00, d);
    endtask : read

    task automatic write(input logic [7:0] a, input logic [7:0] wd);
        logic [7:0] d;
        access(1'b1, a, wd, d);
    endtask : write
endmodule : tsic_cpu_model

// ===== verification/tsic_timer_bench.sv
`timescale 1ns/100ps
`include "tsic_map.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fail_count++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); end end

module tsic_timer_bench
    import tsic_pkg::*;
;
    logic core_clk, srst, clk_en, capture_input_one, capture_input_two, irq_req;
    tsic_bus_t bus_req;
    tsic_ctl_t ctl;
    logic [7:0] rd_data, b, c, d, keep;
    int fail_count = 0;
    int checked = 0;
    int cycles = 0;

    tsic_timer dut (.core_clk(core_clk), .srst(srst), .clk_en(clk_en), .bus_req(bus_req),
        .ctl(ctl), .capture_input_one(capture_input_one),
        .capture_input_two(capture_input_two), .rd_data(rd_data), .irq_req(irq_req));
    tsic_cpu_model cpu (.core_clk(core_clk), .rd_data(rd_data), .bus_req(bus_req));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // Whole run is a few hundred cycles; ceiling leaves wide margin
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            summarize();
        end
    end

    task automatic summarize();
        if (fail_count == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : wait_cyc

    task automatic do_reset();
        srst = 1'b1;
        wait_cyc(6);
        srst = 1'b0;
    endtask : do_reset

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string nm);
        logic [7:0] v;
        cpu.read(a, v);
        `CHK(nm, e, v)
    endtask : rd_chk

    task automatic pulse_one();
        capture_input_one = 1'b0;
        wait_cyc(4);
        capture_input_one = 1'b1;
        wait_cyc(6);
    endtask : pulse_one

    task automatic test_overflow();
        ctl = '{overflow_irq_en: 1'b1, default: 1'b0};
        wait_cyc(20);
        cpu.read(`TSIC_ADDR_CNT_LO, d);
        rd_chk(`TSIC_ADDR_FLAGS, 8'h38, "ovf_set");
        `CHK("ovf_irq", 1'b1, irq_req)
        cpu.read(`TSIC_ADDR_CNT_LO, d);
        rd_chk(`TSIC_ADDR_FLAGS, 8'h18, "ovf_clr");
        wait_cyc(2);
        `CHK("ovf_irq_off", 1'b0, irq_req)
    endtask : test_overflow

    task automatic test_capture_two();
        ctl = '{capture_two_irq_en: 1'b1, default: 1'b0};
        cpu.read(`TSIC_ADDR_CNT_LO, b);
        capture_input_two = 1'b0;
        wait_cyc(6);
        rd_chk(`TSIC_ADDR_FLAGS, 8'h14, "cap2_set");
        `CHK("cap2_irq", 1'b1, irq_req)
        rd_chk(`TSIC_ADDR_CAP2_HI, 8'h00, "cap2_hi");
        cpu.read(`TSIC_ADDR_CAP2_LO, d);
        c = d - b;
        `CHK("cap2_lo", 1'b1, (c >= 8'h01 && c <= 8'h03))
        rd_chk(`TSIC_ADDR_FLAGS, 8'h10, "cap2_clr");
        wait_cyc(2);
        `CHK("cap2_irq_off", 1'b0, irq_req)
        capture_input_two = 1'b1;
        wait_cyc(6);
        rd_chk(`TSIC_ADDR_FLAGS, 8'h18, "cap2_rise");
    endtask : test_capture_two

    task automatic test_capture_one();
        ctl = '{edge_select_one: 1'b1, default: 1'b0};
        capture_input_one = 1'b0;
        wait_cyc(6);
        rd_chk(`TSIC_ADDR_FLAGS, 8'h08, "cap1_fall");
        capture_input_one = 1'b1;
        wait_cyc(6);
        rd_chk(`TSIC_ADDR_FLAGS, 8'h98, "cap1_rise");
        `CHK("cap1_irq_off", 1'b0, irq_req)
        cpu.read(`TSIC_ADDR_CAP1_LO, b);
        pulse_one();
        cpu.read(`TSIC_ADDR_CAP1_LO, c);
        `CHK("cap1_new", 1'b1, c != b)
        pulse_one();
        cpu.read(`TSIC_ADDR_CAP1_LO, d);
        `CHK("cap1_over", 1'b1, d != c)
        cpu.read(`TSIC_ADDR_CAP1_HI, b);
        pulse_one();
        cpu.read(`TSIC_ADDR_CAP1_LO, c);
        `CHK("cap1_block", d, c)
        pulse_one();
        cpu.read(`TSIC_ADDR_CAP1_LO, d);
        `CHK("cap1_free", 1'b1, d != c)
        rd_chk(`TSIC_ADDR_FLAGS, 8'h98, "cap1_held");
        cpu.read(`TSIC_ADDR_CAP1_LO, keep);
        rd_chk(`TSIC_ADDR_FLAGS, 8'h18, "cap1_clr");
    endtask : test_capture_one

    task automatic test_compare(input logic [7:0] hi, input logic [7:0] lo,
        input logic [7:0] m, input tsic_ctl_t en);
        ctl = en;
        cpu.read(`TSIC_ADDR_CNT_LO, b);
        b = b + 8'h14;
        cpu.write(hi, 8'h00);
        cpu.write(lo, b);
        rd_chk(hi, 8'h00, "cmp_hi");
        rd_chk(lo, b, "cmp_lo");
        wait_cyc(100);
        rd_chk(`TSIC_ADDR_FLAGS, 8'h18 | m, "cmp_set");
        `CHK("cmp_irq", 1'b1, irq_req)
        cpu.read(lo, d);
        rd_chk(`TSIC_ADDR_FLAGS, 8'h18, "cmp_clr");
        wait_cyc(2);
        `CHK("cmp_irq_off", 1'b0, irq_req)
    endtask : test_compare

    task automatic test_reset_again();
        ctl = '{overflow_irq_en: 1'b1, default: 1'b0};
        do_reset();
        rd_chk(`TSIC_ADDR_CAP1_LO, keep, "cap_reset");
        wait_cyc(20);
        `CHK("ovf2_irq", 1'b1, irq_req)
        cpu.write(`TSIC_ADDR_FLAGS, 8'h00);
        cpu.read(`TSIC_ADDR_ALT_LO, d);
        `CHK("alt_keep", 1'b1, irq_req)
        cpu.read(`TSIC_ADDR_CNT_LO, d);
        rd_chk(`TSIC_ADDR_FLAGS, 8'h18, "ovf_wr_arm");
    endtask : test_reset_again

    task automatic test_freeze();
        cpu.read(`TSIC_ADDR_CNT_LO, b);
        clk_en = 1'b0;
        wait_cyc(40);
        clk_en = 1'b1;
        cpu.read(`TSIC_ADDR_CNT_LO, c);
        c = c - b;
        `CHK("freeze", 1'b1, c <= 8'h02)
    endtask : test_freeze

    initial begin
        srst = 1'b1;
        clk_en = 1'b1;
        capture_input_one = 1'b1;
        capture_input_two = 1'b1;
        ctl = '0;
        // Compare words have no reset; load them under reset so no match sees unknowns
        cpu.write(`TSIC_ADDR_CMP1_HI, 8'h80);
        cpu.write(`TSIC_ADDR_CMP2_HI, 8'h80);
        cpu.write(`TSIC_ADDR_CMP1_LO, 8'h00);
        cpu.write(`TSIC_ADDR_CMP2_LO, 8'h00);
        do_reset();
        test_overflow();
        test_capture_two();
        test_capture_one();
        test_compare(`TSIC_ADDR_CMP1_HI, `TSIC_ADDR_CMP1_LO, 8'h40,
            '{compare_one_irq_en: 1'b1, default: 1'b0});
        test_compare(`TSIC_ADDR_CMP2_HI, `TSIC_ADDR_CMP2_LO, 8'h02,
            '{compare_two_irq_en: 1'b1, default: 1'b0});
        test_freeze();
        test_reset_again();
        summarize();
    end
endmodule : tsic_timer_bench
